// ---- src/lfb_consts.vh ----
// constants for the lcd frame and boost timing generator
`ifndef LFB_CONSTS_VH
`define LFB_CONSTS_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define LFB_ADDR_CTRL     8'h00
`define LFB_ADDR_STAT     8'h04

// ****************************************************************
// lcd_control_reg field positions
// ****************************************************************
`define LFB_BASE_LO       0
`define LFB_DUTY_LO       2
`define LFB_BOOST_LO      4
`define LFB_BOOSTER_BIT   6
`define LFB_DISP_BIT      7
`define LFB_DIVSEL_BIT    8
`define LFB_SYSSEL_BIT    9
`define LFB_CTRL_W        10
`define LFB_CTRL_RST      10'h000

// ****************************************************************
// status field positions
// ****************************************************************
`define LFB_ST_SLOW_BIT   0
`define LFB_ST_BFLT_BIT   1
`define LFB_ST_SFLT_BIT   2
`define LFB_ST_CNT_LO     16

// ****************************************************************
// drive method codes
// ****************************************************************
`define LFB_DUTY_QUARTER  2'b00
`define LFB_DUTY_THIRD    2'b01
`define LFB_DUTY_HALF     2'b10
`define LFB_DUTY_STATIC   2'b11

// ****************************************************************
// divider exponents (power of two of the source clock)
// ****************************************************************
`define LFB_FAST_BASE0    5'd17
`define LFB_FAST_BASE1    5'd16
`define LFB_FAST_BASE2    5'd15
`define LFB_FAST_BASE3    5'd13
`define LFB_SLOW_BASE0    5'd9
`define LFB_SLOW_BASE1    5'd8
`define LFB_FAST_BST0     5'd13
`define LFB_FAST_BST1     5'd11
`define LFB_FAST_BST2     5'd10
`define LFB_FAST_BST3     5'd9
`define LFB_SLOW_BST0     5'd5
`define LFB_SLOW_BST1     5'd3
`define LFB_SLOW_BST2     5'd2
`define LFB_QUARTER_SHIFT 5'd2

// ****************************************************************
// axi responses
// ****************************************************************
`define LFB_RESP_OKAY     2'b00
`define LFB_RESP_SLVERR   2'b10

`endif

// ---- src/lfb_divider.v ----
// free-running binary prescaler advanced by a one-cycle enable
`default_nettype none

module lfb_divider #(
  parameter W = 17
) (
  // clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  // source rate enable
  input  wire         src_en,
  // prescaler state
  output reg  [W-1:0] cnt_r
);

  always @(posedge aclk)
  begin
    if (!aresetn)
      cnt_r <= {W{1'b0}};
    else if (src_en)
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
  end

endmodule

`default_nettype wire

// ---- src/lfb_timing.v ----
// lcd frame rate and booster reference timing with axi4-lite control
// Functional notes
// - Four drive methods are selectable: 1/4 duty, 1/3 duty, 1/2 duty, static.
// - The base rate is divided down from the active fast or slow clock per base_freq_sel.
// - On the fast clock, base select 00..11 divides by 2^17, 2^16, 2^15, 2^13.
// - With either clock select set, base select 00 and 01 divide the slow clock by 2^9, 2^8.
// - Frame rate is the base rate for 1/4 and static, 4/3 of it for 1/3, twice it for 1/2.
// - booster_on chooses the internal booster, else the external divider on the bias pins.
// - Boost select 00..11 gives fast /2^13,/2^11,/2^10,/2^9 or slow /2^5,/2^3,/2^2, none; here 11 gives fast /2^9 unless system_clock_sel is set.
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`default_nettype none
`include "lfb_consts.vh"

module lfb_timing #(
  parameter FAST_W = 17,
  parameter SLOW_W = 9
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // slow clock pin, sampled as a level
  input  wire        slow_clock_pin,
  // timing strobes and drive controls
  output reg         frame_rate,
  output reg         boost_ref_tick,
  output reg         booster_on,
  output reg         resistor_div_on,
  output reg         display_en,
  output reg  [1:0]  drive_method
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // true when the low n bits of the prescaler are all ones
  function tap;
    input [16:0] cnt;
    input [4:0]  n;
    begin
      tap = &(cnt | ~((17'h00001 << n) - 17'h00001));
    end
  endfunction

  // ****************************************************************
  // registers and state
  // ****************************************************************
  reg  [`LFB_CTRL_W-1:0] lcd_control_reg;
  reg                    slow_s1_r;
  reg                    slow_s2_r;
  reg                    slow_s3_r;
  reg  [1:0]             quarter_r;
  reg  [15:0]            frame_cnt_r;
  reg                    aw_held_r;
  reg                    w_held_r;
  reg  [7:0]             awaddr_r;
  reg  [31:0]            wdata_r;
  reg  [3:0]             wstrb_r;
  wire [FAST_W-1:0]      fast_cnt;
  wire [SLOW_W-1:0]      slow_cnt;
  wire                   slow_tick;

  wire [1:0] base_freq_sel    = lcd_control_reg[`LFB_BASE_LO +: 2];
  wire [1:0] duty_sel         = lcd_control_reg[`LFB_DUTY_LO +: 2];
  wire [1:0] boost_freq_sel   = lcd_control_reg[`LFB_BOOST_LO +: 2];
  wire       divider_clock_sel = lcd_control_reg[`LFB_DIVSEL_BIT];
  wire       system_clock_sel  = lcd_control_reg[`LFB_SYSSEL_BIT];

  // ****************************************************************
  // slow clock synchroniser and rising edge
  // ****************************************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      slow_s1_r <= 1'b0;
      slow_s2_r <= 1'b0;
      slow_s3_r <= 1'b0;
    end
    else
    begin
      slow_s1_r <= slow_clock_pin;
      slow_s2_r <= slow_s1_r;
      slow_s3_r <= slow_s2_r;
    end
  end

  assign slow_tick = slow_s2_r & ~slow_s3_r;

  // ****************************************************************
  // prescalers: fast clock is aclk itself, slow clock is the pin edge
  // ****************************************************************
  lfb_divider #(.W(FAST_W)) u_fast_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .src_en  (1'b1),
    .cnt_r   (fast_cnt)
  );

  lfb_divider #(.W(SLOW_W)) u_slow_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .src_en  (slow_tick),
    .cnt_r   (slow_cnt)
  );

  // ****************************************************************
  // source and tap selection
  // ****************************************************************
  reg       base_use_slow;
  reg       base_ok;
  reg [4:0] base_exp;
  reg       bst_use_slow;
  reg       bst_ok;
  reg [4:0] bst_exp;
  reg       quarter_tick;
  reg       boost_tick;

  wire [16:0] fast_ext = {{(17-FAST_W){1'b0}}, fast_cnt};
  wire [16:0] slow_ext = {{(17-SLOW_W){1'b0}}, slow_cnt};

  always @*
  begin
    base_use_slow = divider_clock_sel | system_clock_sel;
    base_ok       = 1'b1;
    base_exp      = `LFB_FAST_BASE0;
    case (base_freq_sel)
      2'b00: base_exp = base_use_slow ? `LFB_SLOW_BASE0 : `LFB_FAST_BASE0;
      2'b01: base_exp = base_use_slow ? `LFB_SLOW_BASE1 : `LFB_FAST_BASE1;
      2'b10: base_exp = `LFB_FAST_BASE2;
      default: base_exp = `LFB_FAST_BASE3;
    endcase
    // codes 10/11 stay on the fast clock, also with divider_clock_sel set, and stop when system_clock_sel is set
    if (base_freq_sel[1])
    begin
      base_use_slow = 1'b0;
      base_ok       = ~system_clock_sel;
    end
    // frame runs in quarter-base steps so the 4/3 ratio stays exact
    if (base_use_slow)
      quarter_tick = base_ok & slow_tick &
                     tap(slow_ext, base_exp - `LFB_QUARTER_SHIFT);
    else
      quarter_tick = base_ok & tap(fast_ext, base_exp - `LFB_QUARTER_SHIFT);

    bst_use_slow = divider_clock_sel | system_clock_sel;
    bst_ok       = 1'b1;
    case (boost_freq_sel)
      2'b00: bst_exp = bst_use_slow ? `LFB_SLOW_BST0 : `LFB_FAST_BST0;
      2'b01: bst_exp = bst_use_slow ? `LFB_SLOW_BST1 : `LFB_FAST_BST1;
      2'b10: bst_exp = bst_use_slow ? `LFB_SLOW_BST2 : `LFB_FAST_BST2;
      default:
      begin
        bst_exp      = `LFB_FAST_BST3;
        bst_use_slow = 1'b0;
        bst_ok       = ~system_clock_sel;
      end
    endcase
    if (bst_use_slow)
      boost_tick = bst_ok & slow_tick & tap(slow_ext, bst_exp);
    else
      boost_tick = bst_ok & tap(fast_ext, bst_exp);
  end

  // ****************************************************************
  // frame and boost strobes
  // ****************************************************************
  reg [1:0] quarter_last;

  always @*
  begin
    case (duty_sel)
      `LFB_DUTY_THIRD: quarter_last = 2'd2;
      `LFB_DUTY_HALF:  quarter_last = 2'd1;
      default:         quarter_last = 2'd3;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      quarter_r      <= 2'd0;
      frame_rate     <= 1'b0;
      boost_ref_tick <= 1'b0;
      frame_cnt_r    <= 16'h0000;
    end
    else
    begin
      frame_rate     <= 1'b0;
      boost_ref_tick <= boost_tick & booster_on;
      if (quarter_tick)
      begin
        if (quarter_r >= quarter_last)
        begin
          quarter_r   <= 2'd0;
          frame_rate  <= 1'b1;
          frame_cnt_r <= frame_cnt_r + 16'h0001;
        end
        else
          quarter_r <= quarter_r + 2'd1;
      end
    end
  end

  // ****************************************************************
  // drive controls, registered from the control word
  // ****************************************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      booster_on      <= 1'b0;
      resistor_div_on <= 1'b1;
      display_en      <= 1'b0;
      drive_method    <= 2'b00;
    end
    else
    begin
      booster_on      <= lcd_control_reg[`LFB_BOOSTER_BIT];
      resistor_div_on <= ~lcd_control_reg[`LFB_BOOSTER_BIT];
      display_en      <= lcd_control_reg[`LFB_DISP_BIT];
      drive_method    <= duty_sel;
    end
  end

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  wire wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;
  wire wr_hit = (awaddr_r == `LFB_ADDR_CTRL);
  // illegal software settings are only reported, hardware still obeys
  wire bst_fault = lcd_control_reg[`LFB_BOOSTER_BIT] & duty_sel[1];
  wire slow_fault = system_clock_sel &
                    (base_freq_sel[1] | (&boost_freq_sel));
  wire [31:0] stat_word = {frame_cnt_r, 13'h0000, slow_fault, bst_fault,
                           divider_clock_sel | system_clock_sel};

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r       <= 1'b0;
      w_held_r        <= 1'b0;
      awaddr_r        <= 8'h00;
      wdata_r         <= 32'h00000000;
      wstrb_r         <= 4'h0;
      s_axi_awready   <= 1'b0;
      s_axi_wready    <= 1'b0;
      s_axi_bvalid    <= 1'b0;
      s_axi_bresp     <= `LFB_RESP_OKAY;
      lcd_control_reg <= `LFB_CTRL_RST;
    end
    else
    begin
      s_axi_awready <= ~aw_held_r & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `LFB_RESP_OKAY : `LFB_RESP_SLVERR;
        if (wr_hit & wstrb_r[0])
          lcd_control_reg[7:0] <= wdata_r[7:0];
        if (wr_hit & wstrb_r[1])
          lcd_control_reg[9:8] <= wdata_r[9:8];
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `LFB_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `LFB_RESP_OKAY;
        case (s_axi_araddr)
          `LFB_ADDR_CTRL:
            s_axi_rdata <= {22'h000000, lcd_control_reg};
          `LFB_ADDR_STAT:
            s_axi_rdata <= stat_word;
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `LFB_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- verif/lfb_panel_model.sv ----
// panel side model: free slow oscillator and strobe spacing monitor
`default_nettype none

module lfb_panel_model #(
  parameter int HALF = 4
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // strobes from the block
  input  wire logic        frame_rate,
  input  wire logic        boost_ref_tick,
  // slow oscillator
  output var  logic        slow_clock_pin,
  // measured spacing in aclk cycles and strobe counts
  output var  logic [31:0] frame_gap,
  output var  logic [31:0] frame_cnt,
  output var  logic [31:0] boost_gap,
  output var  logic [31:0] boost_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  int          half_cnt = 0;
  logic [31:0] frun;
  logic [31:0] brun;

  // a crystal keeps running through reset
  initial slow_clock_pin = 1'b0;
  always @(posedge aclk)
  begin
    half_cnt <= (half_cnt == HALF - 1) ? 0 : half_cnt + 1;
    if (half_cnt == HALF - 1)
      slow_clock_pin <= ~slow_clock_pin;
  end

  // spacing between consecutive one-cycle strobes
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {frun, brun, frame_cnt, boost_cnt} <= '0;
      {frame_gap, boost_gap} <= '0;
    end
    else
    begin
      frun <= frame_rate ? 32'h0 : frun + 1;
      brun <= boost_ref_tick ? 32'h0 : brun + 1;
      if (frame_rate)
      begin
        frame_gap <= frun + 1;
        frame_cnt <= frame_cnt + 1;
      end
      if (boost_ref_tick)
      begin
        boost_gap <= brun + 1;
        boost_cnt <= boost_cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/lfb_timing_chk.sv ----
// assertion checker for the lcd frame and boost timing block
`default_nettype none
`include "lfb_consts.vh"

module lfb_chk (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // strobes and drive controls
  input wire logic        frame_rate,
  input wire logic        boost_ref_tick,
  input wire logic        booster_on,
  input wire logic        resistor_div_on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_div_mirror: assert property (resistor_div_on == !booster_on)
    else $error("divider select is not the inverse of booster");
  a_frame_gap: assert property (frame_rate |=> !frame_rate [*8])
    else $error("frame strobe too long or too close");
  a_boost_pulse: assert property (boost_ref_tick |=> !boost_ref_tick)
    else $error("boost strobe longer than one cycle");
  a_boost_gated: assert property
    (boost_ref_tick |-> booster_on || $past(booster_on))
    else $error("boost strobe while booster off");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_w_pulse: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("wready longer than one cycle");
  a_r_hold: assert property
    (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("no read data one cycle after address");
  a_wr_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("no write response after address and data");
  a_rd_unmapped: assert property ((s_rd_taken and
    (s_axi_araddr != `LFB_ADDR_CTRL && s_axi_araddr != `LFB_ADDR_STAT))
    |=> s_axi_rresp == `LFB_RESP_SLVERR)
    else $error("unmapped read not refused");
endmodule

bind lfb_timing lfb_chk i_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .frame_rate, .boost_ref_tick, .booster_on,
  .resistor_div_on
);
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the lcd frame and boost timing block
`default_nettype none
`include "lfb_consts.vh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLOWP = 8; // aclk cycles per rising slow clock edge
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, frame_rate, boost_ref_tick, booster_on;
  logic        resistor_div_on, display_en, slow_clock_pin;
  logic [1:0]  s_axi_bresp, s_axi_rresp, drive_method;
  logic [31:0] s_axi_rdata, frame_gap, frame_cnt, boost_gap, boost_cnt;
  int          mismatches = 0;
  int          checks = 0;

  always #4 aclk = ~aclk;

  lfb_timing i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .slow_clock_pin, .frame_rate,
    .boost_ref_tick, .booster_on, .resistor_div_on, .display_en,
    .drive_method
  );
  lfb_panel_model i_panel (
    .aclk, .aresetn, .frame_rate, .boost_ref_tick, .slow_clock_pin,
    .frame_gap, .frame_cnt, .boost_gap, .boost_cnt
  );

  // ****************************************************************
  // reporting and bus tasks
  // ****************************************************************
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic hang(input string what);
    mismatches++;
    $display("MISMATCH %0t %s timed out", $time, what);
    print_verdict();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (n > 64)
        hang("write");
    end
    while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      // late ready makes the slave hold its answer
      if (s_axi_rvalid)
        s_axi_rready <= 1'b1;
      if (n > 64)
        hang("read");
    end
    while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic cfg(input logic [31:0] d);
    logic [1:0] r;
    axi_wr(`LFB_ADDR_CTRL, d, 4'hf, r);
    chk(r, `LFB_RESP_OKAY, "control write");
  endtask

  // waits out the irregular frame after a change, then two full gaps, and checks the last
  task automatic gap(input bit bst, input int exp, input string what);
    logic [31:0] c0;
    int          n;
    c0 = bst ? boost_cnt : frame_cnt;
    n = 0;
    while ((bst ? boost_cnt : frame_cnt) - c0 < 3)
    begin
      @(posedge aclk);
      n++;
      if (n > 4 * exp + 64)
        hang(what);
    end
    chk(bst ? boost_gap : frame_gap, exp, what);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset(input string what);
    logic [31:0] d;
    logic [1:0]  r;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({resistor_div_on, booster_on}, 2'b10, "bias source");
    chk({display_en, drive_method}, 3'b000, "display controls");
    axi_rd(`LFB_ADDR_CTRL, d, r);
    chk(d, `LFB_CTRL_RST, "control reset value");
    $display("done %s", what);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    cfg(32'h0000_00c5);
    repeat (2) @(posedge aclk);
    chk({resistor_div_on, booster_on, display_en, drive_method}, 5'b01101,
        "controls out");
    axi_wr(`LFB_ADDR_CTRL, 32'hffff_ff00, 4'h2, r);
    axi_rd(`LFB_ADDR_CTRL, d, r);
    chk(d, 32'h0000_03c5, "byte lane write");
    axi_rd(`LFB_ADDR_STAT, d, r);
    chk(d[2:0], 3'b001, "slow source status");
    axi_rd(8'h08, d, r);
    chk(r, `LFB_RESP_SLVERR, "unmapped read response");
    chk(d, 32'h0, "unmapped read data");
    axi_wr(8'h08, 32'h0, 4'hf, r);
    chk(r, `LFB_RESP_SLVERR, "unmapped write");
    axi_wr(`LFB_ADDR_STAT, 32'h0, 4'hf, r);
    chk(r, `LFB_RESP_SLVERR, "status write");
    axi_rd(`LFB_ADDR_CTRL, d, r);
    chk(d, 32'h0000_03c5, "refused writes ignored");
    $display("done registers");
  endtask

  task automatic t_duty;
    int q[4] = '{4, 3, 2, 4};
    for (int m = 0; m < 4; m++)
    begin
      cfg(32'h0000_0101 | (m << 2));
      gap(0, 256 * SLOWP * q[m] / 4, "frame per method");
      chk(drive_method, m[1:0], "method out");
    end
    cfg(32'h0000_0003);
    gap(0, 1 << 13, "fast base");
    cfg(32'h0000_0200);
    gap(0, 512 * SLOWP, "slow base");
    $display("done frame rates");
  endtask

  task automatic t_boost;
    int          fe[4] = '{13, 11, 10, 9};
    int          se[3] = '{5, 3, 2};
    logic [31:0] c0;
    for (int c = 1; c < 4; c++)
    begin
      cfg(32'h0000_0043 | (c << 4));
      gap(1, 1 << fe[c], "fast boost");
    end
    for (int c = 0; c < 3; c++)
    begin
      cfg(32'h0000_0140 | (c << 4));
      gap(1, (1 << se[c]) * SLOWP, "slow boost");
    end
    cfg(32'h0000_0100);
    repeat (4) @(posedge aclk);
    c0 = boost_cnt;
    repeat (600) @(posedge aclk);
    chk(boost_cnt - c0, 32'h0, "no boost when divider used");
    $display("done boost rates");
  endtask

  initial
  begin
    t_reset("reset");
    t_regs();
    t_duty();
    t_boost();
    t_reset("second reset");
    print_verdict();
  end
endmodule
`default_nettype wire
